// *** alm_b_pkg.sv ***
// Constants for the second alarm: register indices, fields, reset values, timing
`default_nettype none
package alm_b_pkg;
	// ----------------------------------------------------------------
	// Register indices (word address on the bus)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_SUBSEC  = 6'h12;
	localparam logic [5:0] IDX_SEC     = 6'h13;
	localparam logic [5:0] IDX_MIN     = 6'h14;
	localparam logic [5:0] IDX_HOUR    = 6'h15;
	localparam logic [5:0] IDX_DAYCTL  = 6'h16;
	localparam logic [5:0] IDX_DATE    = 6'h17;
	localparam logic [5:0] IDX_MONTH   = 6'h20;
	// ----------------------------------------------------------------
	// Writable bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_SUBSEC = 8'hff;
	localparam logic [7:0] MASK_SEC    = 8'h7f;
	localparam logic [7:0] MASK_MIN    = 8'h7f;
	localparam logic [7:0] MASK_HOUR   = 8'h7f;
	localparam logic [7:0] MASK_DATE   = 8'h3f;
	localparam logic [7:0] MASK_MONTH  = 8'h1f;
	localparam logic [7:0] RST_VALUE   = 8'h00;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_OUT_SEL  = 7;
	localparam int BIT_COND_HI  = 6;
	localparam int BIT_COND_LO  = 4;
	localparam int BIT_FLAG     = 3;
	localparam int BIT_DAY_HI   = 2;
	localparam int BIT_FMT12    = 6;
	localparam int BIT_PM       = 5;
	// ----------------------------------------------------------------
	// Match-condition codes
	// ----------------------------------------------------------------
	localparam logic [2:0] COND_SEC   = 3'h0;
	localparam logic [2:0] COND_MIN   = 3'h1;
	localparam logic [2:0] COND_HOUR  = 3'h2;
	localparam logic [2:0] COND_DAY   = 3'h3;
	localparam logic [2:0] COND_DATE  = 3'h4;
	localparam logic [2:0] COND_ALL   = 3'h7;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 25000000;
	localparam int WDO_PULSE_MS    = 122;
	localparam int WDO_PULSE_CYC   = (CLK_HZ / 1000) * WDO_PULSE_MS;
endpackage : alm_b_pkg
`default_nettype wire

// *** alm_b_match.sv ***
// Second alarm: compare registers, match logic, sticky flag and pin drive
//
// Overview of operation
// - With the output select bit clear the alarm is shown on the interrupt pin only.
// - With the output select bit set an alarm drives the watchdog pin low for a 122 ms pulse.
// - The three-bit condition code chooses seconds, minutes, hours, day, date or all fields.
// - Hours matching compares true hours, honouring 12/24 format and the AM/PM bit.
// - Day matching fires once at 12:00:00 AM of the matching weekday.
// - Code 111 fires only when subseconds, seconds, minutes, hour, day, date and month all match.
// - Hardware sets the event flag on every alarm and it stays set until cleared.
// - The compare set includes tenths and hundredths of seconds.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module alm_b_match #(
	parameter int PULSE_CYCLES = alm_b_pkg::WDO_PULSE_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [7:0]  cur_subsec,
	input  wire logic [7:0]  cur_sec,
	input  wire logic [7:0]  cur_min,
	input  wire logic [7:0]  cur_hour,
	input  wire logic [2:0]  cur_day,
	input  wire logic [7:0]  cur_date,
	input  wire logic [7:0]  cur_month,
	output logic             irq_pin_out,
	output logic             irq_pin_oe,
	output logic             watchdog_output_pin_out,
	output logic             watchdog_output_pin_oe
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Converts a BCD hour byte in either format to a 0..23 binary hour
	function automatic logic [4:0] alm_b_to_h24(input logic [7:0] h);
		logic [4:0] units;
		logic [4:0] val;
		units = {1'b0, h[3:0]};
		val = 5'h00;
		if (h[alm_b_pkg::BIT_FMT12]) begin
			val = h[4] ? (units + 5'h0a) : units;
			if (val == 5'h0c)
				val = 5'h00;
			if (h[alm_b_pkg::BIT_PM])
				val = val + 5'h0c;
		end else begin
			val = units + (h[4] ? 5'h0a : 5'h00) + (h[5] ? 5'h14 : 5'h00);
		end
		return val;
	endfunction : alm_b_to_h24

	// ----------------------------------------------------------------
	// Compare registers
	// ----------------------------------------------------------------
	logic [7:0]  subsec_r;
	logic [7:0]  sec_r;
	logic [7:0]  min_r;
	logic [7:0]  hour_r;
	logic [7:0]  dayctl_r;
	logic [7:0]  date_r;
	logic [7:0]  month_r;
	logic        ack_r;
	logic [31:0] rdata_r;
	logic        match_prev_r;
	logic [31:0] pulse_cnt_r;

	wire         req        = avs_read | avs_write;
	wire         wr_go      = avs_write & ack_r;
	wire [7:0]   wbyte      = avs_writedata[7:0];
	wire         out_sel    = dayctl_r[alm_b_pkg::BIT_OUT_SEL];
	wire [2:0]   match_cond = dayctl_r[alm_b_pkg::BIT_COND_HI:alm_b_pkg::BIT_COND_LO];
	wire         event_flag = dayctl_r[alm_b_pkg::BIT_FLAG];

	// Bus answers one cycle after a request is seen
	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata    = rdata_r;

	// ----------------------------------------------------------------
	// Read selection
	// ----------------------------------------------------------------
	logic [7:0] rd_byte;
	always_comb begin
		case (avs_address)
			alm_b_pkg::IDX_SUBSEC: rd_byte = subsec_r;
			alm_b_pkg::IDX_SEC:    rd_byte = sec_r;
			alm_b_pkg::IDX_MIN:    rd_byte = min_r;
			alm_b_pkg::IDX_HOUR:   rd_byte = hour_r & alm_b_pkg::MASK_HOUR;
			alm_b_pkg::IDX_DAYCTL: rd_byte = dayctl_r;
			alm_b_pkg::IDX_DATE:   rd_byte = date_r;
			alm_b_pkg::IDX_MONTH:  rd_byte = month_r;
			default:               rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Field comparisons
	// ----------------------------------------------------------------
	wire        hit_sub   = (cur_subsec == subsec_r);
	wire        hit_sec   = (cur_sec[6:0] == sec_r[6:0]);
	wire        hit_min   = (cur_min[6:0] == min_r[6:0]);
	wire        hit_hour  = (alm_b_to_h24(cur_hour) == alm_b_to_h24(hour_r));
	wire        hit_day   = (cur_day == dayctl_r[alm_b_pkg::BIT_DAY_HI:0]);
	wire        hit_date  = (cur_date[5:0] == date_r[5:0]);
	wire        hit_month = (cur_month[4:0] == month_r[4:0]);
	wire        midnight  = (alm_b_to_h24(cur_hour) == 5'h00) && (cur_min[6:0] == 7'h00)
		&& (cur_sec[6:0] == 7'h00) && (cur_subsec == 8'h00);

	logic match_now;
	always_comb begin
		case (match_cond)
			alm_b_pkg::COND_SEC:  match_now = hit_sec & hit_sub;
			alm_b_pkg::COND_MIN:  match_now = hit_min;
			alm_b_pkg::COND_HOUR: match_now = hit_hour;
			alm_b_pkg::COND_DAY:  match_now = hit_day & midnight;
			alm_b_pkg::COND_DATE: match_now = hit_date;
			alm_b_pkg::COND_ALL:  match_now = hit_sub & hit_sec & hit_min & hit_hour
				& hit_day & hit_date & hit_month;
			default:              match_now = 1'b0;
		endcase
	end

	// One event per entry into the matching state
	wire alarm_evt = match_now & ~match_prev_r;

	// ----------------------------------------------------------------
	// Bus handshake and registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req & ~ack_r;
			if (req & ~ack_r)
				rdata_r <= {24'h00_0000, rd_byte};
		end
	end

	// Compare registers with masked writes
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			subsec_r <= alm_b_pkg::RST_VALUE;
			sec_r    <= alm_b_pkg::RST_VALUE;
			min_r    <= alm_b_pkg::RST_VALUE;
			hour_r   <= alm_b_pkg::RST_VALUE;
			date_r   <= alm_b_pkg::RST_VALUE;
			month_r  <= alm_b_pkg::RST_VALUE;
		end else if (wr_go) begin
			if (avs_address == alm_b_pkg::IDX_SUBSEC)
				subsec_r <= wbyte & alm_b_pkg::MASK_SUBSEC;
			if (avs_address == alm_b_pkg::IDX_SEC)
				sec_r <= wbyte & alm_b_pkg::MASK_SEC;
			if (avs_address == alm_b_pkg::IDX_MIN)
				min_r <= wbyte & alm_b_pkg::MASK_MIN;
			if (avs_address == alm_b_pkg::IDX_HOUR)
				hour_r <= wbyte & alm_b_pkg::MASK_HOUR;
			if (avs_address == alm_b_pkg::IDX_DATE)
				date_r <= wbyte & alm_b_pkg::MASK_DATE;
			if (avs_address == alm_b_pkg::IDX_MONTH)
				month_r <= wbyte & alm_b_pkg::MASK_MONTH;
		end
	end

	// Day/control register; flag set by an alarm beats a clearing write
	wire dayctl_wr = wr_go & (avs_address == alm_b_pkg::IDX_DAYCTL);
	logic [7:0] dayctl_nxt;
	always_comb begin
		dayctl_nxt = dayctl_r;
		if (dayctl_wr) begin
			dayctl_nxt = wbyte;
			dayctl_nxt[alm_b_pkg::BIT_FLAG] = event_flag & wbyte[alm_b_pkg::BIT_FLAG];
		end
		if (alarm_evt)
			dayctl_nxt[alm_b_pkg::BIT_FLAG] = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dayctl_r     <= alm_b_pkg::RST_VALUE;
			match_prev_r <= 1'b0;
		end else begin
			dayctl_r     <= dayctl_nxt;
			match_prev_r <= match_now;
		end
	end

	// ----------------------------------------------------------------
	// Output pins (open drain, pulled low when asserted)
	// ----------------------------------------------------------------
	// watchdog pulse timer
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			pulse_cnt_r <= 32'h0000_0000;
		else if (alarm_evt & out_sel)
			pulse_cnt_r <= 32'(PULSE_CYCLES);
		else if (pulse_cnt_r != 32'h0000_0000)
			pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
	end

	assign irq_pin_out             = 1'b0;
	assign irq_pin_oe              = event_flag & ~out_sel;
	assign watchdog_output_pin_out = 1'b0;
	assign watchdog_output_pin_oe  = (pulse_cnt_r != 32'h0000_0000);
endmodule : alm_b_match
`default_nettype wire

// *** alm_b_props.sv ***
// Port checker for the second alarm block
`timescale 1ns/1ns
`default_nettype none
module alm_b_props #(parameter int PULSE_CYCLES = 8) (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        irq_pin_out,
	input wire logic        irq_pin_oe,
	input wire logic        watchdog_output_pin_out,
	input wire logic        watchdog_output_pin_oe
);
	logic [31:0] hi_cnt_r;
	// Counts cycles the watchdog enable has stood high
	always_ff @(posedge sys_clk) begin
		hi_cnt_r <= (sys_rst || !watchdog_output_pin_oe) ? 32'h0 : hi_cnt_r + 32'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state too long");
	AST_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest while idle");
	AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	AST_RD_UNMAP: assert property (avs_read && !avs_waitrequest && avs_address == 6'h3f
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	AST_OD_LOW: assert property (!irq_pin_out && !watchdog_output_pin_out)
		else $error("open-drain data not low");
	AST_WDO_MAX: assert property (watchdog_output_pin_oe |-> hi_cnt_r < PULSE_CYCLES)
		else $error("watchdog pulse too long");
	AST_WDO_END: assert property ($fell(watchdog_output_pin_oe) |-> hi_cnt_r == PULSE_CYCLES)
		else $error("watchdog pulse wrong length");
	AST_WDO_NO_IRQ: assert property ($rose(watchdog_output_pin_oe) |-> !irq_pin_oe)
		else $error("both pins signal the alarm");
	AST_IRQ_STICKY: assert property ($fell(irq_pin_oe) |-> $past(avs_write && !avs_waitrequest))
		else $error("interrupt dropped without a write");
endmodule : alm_b_props
bind alm_b_match alm_b_props #(.PULSE_CYCLES(PULSE_CYCLES)) alm_b_props_inst (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
	.watchdog_output_pin_out(watchdog_output_pin_out),
	.watchdog_output_pin_oe(watchdog_output_pin_oe));
`default_nettype wire

// *** alm_b_pins.sv ***
// Host-side model of the two open-drain alarm lines
`timescale 1ns/1ns
`default_nettype none
module alm_b_pins (
	input wire logic irq_out,
	input wire logic irq_oe,
	input wire logic wdo_out,
	input wire logic wdo_oe,
	output logic     irq_line_n,
	output logic     wdo_line_n
);
	// Pull-ups hold each line high unless the block drives it
	assign irq_line_n = irq_oe ? irq_out : 1'b1;
	assign wdo_line_n = wdo_oe ? wdo_out : 1'b1;
endmodule : alm_b_pins
`default_nettype wire

// *** alm_b_match_tb.sv ***
// Testbench for the second alarm block
`timescale 1ns/1ns
`default_nettype none
module alm_b_match_tb;
	localparam int PULSE = 8;
	logic        sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [5:0]  avs_address = 6'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic        avs_waitrequest, irq_out, irq_oe, wdo_out, wdo_oe, irq_line_n, wdo_line_n;
	logic [7:0]  dc;
	logic [7:0]  cur [7] = '{default: 8'h01}; // Off-match time, so reset raises no alarm
	logic [7:0]  cmp [7] = '{8'h12, 8'h34, 8'h56, 8'h07, 8'h03, 8'h15, 8'h09};
	logic [7:0]  alt [7] = '{8'h99, 8'h21, 8'h43, 8'h67, 8'h05, 8'h28, 8'h11};
	logic [6:0]  rel [8] = '{7'h03, 7'h04, 7'h08, 7'h10, 7'h20, 7'h00, 7'h00, 7'h7f};
	int          mf [8] = '{0, 2, 3, 3, 5, 0, 0, 6};
	logic [5:0]  idx [7] = '{alm_b_pkg::IDX_SUBSEC, alm_b_pkg::IDX_SEC, alm_b_pkg::IDX_MIN,
		alm_b_pkg::IDX_HOUR, alm_b_pkg::IDX_DAYCTL, alm_b_pkg::IDX_DATE, alm_b_pkg::IDX_MONTH};
	int          miscompares = 0, num_checks = 0, wcnt = 0;
	alm_b_match #(.PULSE_CYCLES(PULSE)) alm_b_match_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cur_subsec(cur[0]), .cur_sec(cur[1]),
		.cur_min(cur[2]), .cur_hour(cur[3]), .cur_day(cur[4][2:0]), .cur_date(cur[5]),
		.cur_month(cur[6]), .irq_pin_out(irq_out), .irq_pin_oe(irq_oe),
		.watchdog_output_pin_out(wdo_out), .watchdog_output_pin_oe(wdo_oe));
	alm_b_pins alm_b_pins_inst (.irq_out(irq_out), .irq_oe(irq_oe), .wdo_out(wdo_out),
		.wdo_oe(wdo_oe), .irq_line_n(irq_line_n), .wdo_line_n(wdo_line_n));
	// Clock and watchdog pulse counter
	initial forever #20 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (wdo_line_n === 1'b0) wcnt++;
	task report_and_stop;
		if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One bus access; held until waitrequest is sampled low at a rising edge
	task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		chk("wait_cycles", 32'h2, n);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc
	// Current time: 0 nothing matches, 1 near miss, 2 match for code c
	task settime(input int c, input int m);
		for (int i = 0; i < 7; i++) begin
			if (m == 1) cur[i] <= (i == mf[c]) ? alt[i] : cmp[i];
			else if (m == 2 && c == 3 && i < 4) cur[i] <= 8'h00;
			else if (m == 2 && c == 2 && i == 3) cur[i] <= 8'h47;
			else cur[i] <= (m == 2 && rel[c][i]) ? cmp[i] : alt[i];
		end
	endtask : settime
	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		$display("CHECK FAILED run expected end seen hang");
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			acc(1'b0, idx[i], 8'h00);
			chk("reset", 32'h0, rd);
		end
		acc(1'b1, alm_b_pkg::IDX_HOUR, 8'hff);
		acc(1'b0, alm_b_pkg::IDX_HOUR, 8'h00);
		chk("hour", 32'h7f, rd);
		acc(1'b1, 6'h3f, 8'hff);
		acc(1'b0, 6'h3f, 8'h00);
		chk("unmapped", 32'h0, rd);
		for (int i = 0; i < 7; i++) if (i != 4) acc(1'b1, idx[i], cmp[i]);
		acc(1'b0, alm_b_pkg::IDX_SUBSEC, 8'h00);
		chk("subsec", 32'h12, rd);
		// Codes 101 and 110 are skipped since rel is zero for them
		for (int s = 0; s < 2; s++) for (int c = 0; c < 8; c++) if (rel[c] != 7'h0) begin
			settime(c, 0);
			dc = {s[0], c[2:0], 1'b1, cmp[4][2:0]};
			acc(1'b1, alm_b_pkg::IDX_DAYCTL, dc);
			settime(c, 1);
			acc(1'b0, alm_b_pkg::IDX_DAYCTL, 8'h00);
			chk("miss", {24'h0, dc & 8'hf7}, rd);
			wcnt = 0;
			settime(c, 2);
			repeat (PULSE + 4) @(posedge sys_clk);
			chk("pulse", s ? PULSE : 0, wcnt);
			chk("irq_line", {31'h0, s[0]}, {31'h0, irq_line_n});
			settime(c, 1);
			acc(1'b0, alm_b_pkg::IDX_DAYCTL, 8'h00);
			chk("sticky", {24'h0, dc}, rd);
			acc(1'b1, alm_b_pkg::IDX_DAYCTL, dc & 8'hf7);
			acc(1'b0, alm_b_pkg::IDX_DAYCTL, 8'h00);
			chk("clear", {24'h0, dc & 8'hf7}, rd);
		end
		report_and_stop;
	end
endmodule : alm_b_match_tb
`default_nettype wire
